// ---- design/dbi_exec.sv ----
/*
 * Execution slice for decrement-and-branch-if-nonzero and increment-by-one.
 * Assumes the core presents fetched bytes, the operand byte read from RAM,
 * SFR or the port output latch, the accumulator, bank select and PC, and
 * applies the write request and new PC when done_o pulses.
 */
// Functional notes
// - register decrement-branch: PC past instruction, decrement, branch if nonzero
// - direct decrement-branch: decrement byte, branch from updated PC if nonzero
// - direct decrement-branch: three bytes opcode, address, offset; two cycles
// - increment adds one; operand is the accumulator or by register or direct addressing
// - increment of 0FFH wraps to 00H with no carry indication
// - increments leave all status flags unchanged
// - port increment reads output latch, writes result back to latch
// - accumulator increment decoded from opcode 00000100
// - register increment is one byte 00001rrr, one cycle
// - direct increment is 00000101 plus address, one cycle
// - decrement of 00H wraps to 0FFH, branch taken, flags unchanged
// - target is advanced PC plus signed last instruction byte
`timescale 1ns/1ps
module dbi_exec (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// instruction issue
	input wire logic start_i,
	input wire dbi_pkg::dbi_instr_t instr_i,
	input wire logic [15:0] pc_i,
	input wire logic [1:0] bank_i,
	input wire logic [7:0] acc_i,
	input wire logic [7:0] operand_i,
	input wire logic [7:0] psw_i,
	// operand address, source hint, busy and accept handshake
	output logic [7:0] rd_addr_o,
	output logic rd_from_latch_o,
	output logic busy_o,
	output logic accept_o,
	// results
	output logic done_o,
	output logic [15:0] pc_o,
	output logic branch_o,
	output dbi_pkg::dbi_wr_t wr_o,
	output logic [7:0] psw_o
);
	// ----------------------------------------
	// decode
	// ----------------------------------------
	dbi_pkg::dbi_op_t dec_op;
	logic [1:0] dec_len;
	logic [1:0] dec_cyc;

	dbi_decode u_decode (
		.opcode_i(instr_i.opcode),
		.op_o(dec_op),
		.len_o(dec_len),
		.cycles_o(dec_cyc)
	);

	typedef enum logic [1:0] {ST_IDLE, ST_WAIT} dbi_state_t;

	dbi_state_t state_r, state_nxt;
	logic [1:0] cnt_r, cnt_nxt;
	logic done_r, done_nxt;
	logic [15:0] pc_r, pc_nxt;
	logic branch_r, branch_nxt;
	dbi_pkg::dbi_wr_t wr_r, wr_nxt;
	logic [7:0] psw_r, psw_nxt;

	logic [7:0] wreg_addr;
	logic [7:0] op_addr;
	logic [7:0] src;
	logic [7:0] inc_val;
	logic [7:0] dec_val;
	logic [15:0] pc_adv;
	logic [15:0] pc_rel;
	logic [7:0] rel_byte;

	// ----------------------------------------
	// operand addressing
	// ----------------------------------------
	// bank bits above the three-bit selector
	assign wreg_addr = {3'h0, bank_i, instr_i.opcode[dbi_pkg::WSEL_MSB:dbi_pkg::WSEL_LSB]};

	always_comb begin
		unique case (dec_op)
			dbi_pkg::DBI_INC_DIR, dbi_pkg::DBI_DBNZ_DIR: op_addr = instr_i.byte1;
			default: op_addr = wreg_addr;
		endcase
	end

	assign rd_addr_o = op_addr;
	// SFR-space operand: core must return the port output latch, not the pins
	assign rd_from_latch_o = (dec_op == dbi_pkg::DBI_INC_DIR || dec_op == dbi_pkg::DBI_DBNZ_DIR)
		&& (op_addr >= dbi_pkg::SFR_BASE);
	assign busy_o = (state_r != ST_IDLE);
	assign accept_o = start_i && (state_r == ST_IDLE) && (dec_op != dbi_pkg::DBI_NONE);

	// ----------------------------------------
	// arithmetic
	// ----------------------------------------
	assign src = (dec_op == dbi_pkg::DBI_INC_ACC) ? acc_i : operand_i;
	// 8-bit add drops the carry on purpose: 0FFH wraps to 00H silently
	assign inc_val = src + dbi_pkg::BYTE_ONE;
	// 00H wraps to 0FFH, which is nonzero and so branches
	assign dec_val = src - dbi_pkg::BYTE_ONE;
	assign pc_adv = pc_i + {14'h0, dec_len};
	// offset is in the last byte: byte1 for register form, byte2 for direct
	assign rel_byte = (dec_op == dbi_pkg::DBI_DBNZ_DIR) ? instr_i.byte2 : instr_i.byte1;
	assign pc_rel = pc_adv + {{8{rel_byte[7]}}, rel_byte};

	// ----------------------------------------
	// sequencing
	// ----------------------------------------
	// one-cycle ops finish straight from idle; two-cycle ops park in ST_WAIT
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		done_nxt = 1'b0;
		unique case (state_r)
			ST_IDLE: begin
				if (accept_o) begin
					cnt_nxt = dec_cyc - dbi_pkg::CYC_INC;
					if (dec_cyc == dbi_pkg::CYC_INC) begin
						done_nxt = 1'b1;
					end else begin
						state_nxt = ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				// results were captured at accept; this cycle only pads timing
				// start_i is refused here, since accept_o needs idle
				cnt_nxt = cnt_r - dbi_pkg::CYC_INC;
				if (cnt_r == dbi_pkg::CYC_INC) begin
					done_nxt = 1'b1;
					state_nxt = ST_IDLE;
				end
			end
			// unused code of the state register: recover to idle
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_r <= ST_IDLE;
			cnt_r <= '0;
			done_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			done_r <= done_nxt;
		end
	end

	// ----------------------------------------
	// results
	// ----------------------------------------
	// captured at accept and held, so the core may pick them up late
	always_comb begin
		pc_nxt = pc_r;
		branch_nxt = branch_r;
		wr_nxt = wr_r;
		wr_nxt.we = 1'b0;
		psw_nxt = psw_r;
		if (accept_o) begin
			// flags pass straight through on every variant
			psw_nxt = psw_i;
			pc_nxt = pc_adv;
			branch_nxt = 1'b0;
			wr_nxt.we = 1'b1;
			wr_nxt.to_acc = 1'b0;
			wr_nxt.to_port_latch = rd_from_latch_o;
			wr_nxt.addr = op_addr;
			wr_nxt.data = inc_val;
			unique case (dec_op)
				dbi_pkg::DBI_INC_ACC: begin
					wr_nxt.to_acc = 1'b1;
				end
				dbi_pkg::DBI_INC_WREG, dbi_pkg::DBI_INC_DIR: begin
					wr_nxt.data = inc_val;
				end
				// decrement-branch forms: register and direct share this path
				default: begin
					wr_nxt.data = dec_val;
					if (dec_val != dbi_pkg::BYTE_ZERO) begin
						pc_nxt = pc_rel;
						branch_nxt = 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pc_r <= '0;
			branch_r <= 1'b0;
			wr_r <= '0;
			psw_r <= '0;
		end else begin
			pc_r <= pc_nxt;
			branch_r <= branch_nxt;
			wr_r <= wr_nxt;
			psw_r <= psw_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// results stand until the next accepted instruction; write strobe waits for done
	assign done_o = done_r;
	assign pc_o = pc_r;
	assign branch_o = branch_r;
	assign psw_o = psw_r;
	always_comb begin
		wr_o = wr_r;
		wr_o.we = done_r;
	end
endmodule : dbi_exec

// ---- design/dbi_pkg.sv ----
/*
 * Package for the decrement-branch / increment execution slice:
 * opcode encodings, lengths, cycle counts and carrier structs.
 * Assumes an 8051-style core feeds fetched bytes and owns RAM, PSW and ports.
 */
package dbi_pkg;
	// ----------------------------------------
	// opcode encodings
	// ----------------------------------------
	localparam logic [7:0] OP_INC_ACC = 8'h04;
	localparam logic [7:0] OP_INC_DIR = 8'h05;
	localparam logic [4:0] OP_INC_WREG_HI = 5'h01;
	localparam logic [4:0] OP_DBNZ_WREG_HI = 5'h1B;
	localparam logic [7:0] OP_DBNZ_DIR = 8'hD5;

	// ----------------------------------------
	// lengths and cycle counts
	// ----------------------------------------
	localparam logic [1:0] LEN_INC_ACC = 2'h1;
	localparam logic [1:0] LEN_INC_WREG = 2'h1;
	localparam logic [1:0] LEN_INC_DIR = 2'h2;
	localparam logic [1:0] LEN_DBNZ_WREG = 2'h2;
	localparam logic [1:0] LEN_DBNZ_DIR = 2'h3;
	localparam logic [1:0] CYC_INC = 2'h1;
	localparam logic [1:0] CYC_DBNZ = 2'h2;

	// ----------------------------------------
	// field layout and constants
	// ----------------------------------------
	localparam int WSEL_LSB = 0;
	localparam int WSEL_MSB = 2;
	localparam int BANK_LSB = 3;
	localparam logic [7:0] BYTE_ONE = 8'h01;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] SFR_BASE = 8'h80;

	typedef enum logic [2:0] {
		DBI_NONE,
		DBI_INC_ACC,
		DBI_INC_WREG,
		DBI_INC_DIR,
		DBI_DBNZ_WREG,
		DBI_DBNZ_DIR
	} dbi_op_t;

	// fetched instruction bytes as handed in by the core
	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] byte1;
		logic [7:0] byte2;
	} dbi_instr_t;

	// one byte write request towards RAM, SFR or port latch
	typedef struct packed {
		logic we;
		logic to_acc;
		logic to_port_latch;
		logic [7:0] addr;
		logic [7:0] data;
	} dbi_wr_t;
endpackage : dbi_pkg

// ---- design/dbi_decode.sv ----
/*
 * Opcode classifier for the slice: kind, length and cycle count.
 * Assumes the opcode byte is stable while exec start is presented.
 */
`timescale 1ns/1ps
module dbi_decode (
	// opcode
	input wire logic [7:0] opcode_i,
	// classification
	output dbi_pkg::dbi_op_t op_o,
	output logic [1:0] len_o,
	output logic [1:0] cycles_o
);
	always_comb begin
		op_o = dbi_pkg::DBI_NONE;
		len_o = 2'h0;
		cycles_o = 2'h0;
		if (opcode_i == dbi_pkg::OP_INC_ACC) begin
			op_o = dbi_pkg::DBI_INC_ACC;
			len_o = dbi_pkg::LEN_INC_ACC;
			cycles_o = dbi_pkg::CYC_INC;
		end else if (opcode_i == dbi_pkg::OP_INC_DIR) begin
			op_o = dbi_pkg::DBI_INC_DIR;
			len_o = dbi_pkg::LEN_INC_DIR;
			cycles_o = dbi_pkg::CYC_INC;
		end else if (opcode_i[7:3] == dbi_pkg::OP_INC_WREG_HI) begin
			op_o = dbi_pkg::DBI_INC_WREG;
			len_o = dbi_pkg::LEN_INC_WREG;
			cycles_o = dbi_pkg::CYC_INC;
		end else if (opcode_i == dbi_pkg::OP_DBNZ_DIR) begin
			op_o = dbi_pkg::DBI_DBNZ_DIR;
			len_o = dbi_pkg::LEN_DBNZ_DIR;
			cycles_o = dbi_pkg::CYC_DBNZ;
		end else if (opcode_i[7:3] == dbi_pkg::OP_DBNZ_WREG_HI) begin
			op_o = dbi_pkg::DBI_DBNZ_WREG;
			len_o = dbi_pkg::LEN_DBNZ_WREG;
			cycles_o = dbi_pkg::CYC_DBNZ;
		end
	end
endmodule : dbi_decode

// ---- tb/dbi_exec_monitor.sv ----
/*
 * Checker for dbi_exec: timing, data and PC relations at its ports.
 * Assumes one clock domain and that it is bound to every dbi_exec.
 */
`timescale 1ns/1ps
module dbi_exec_monitor (
	// clock, reset, issue
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire dbi_pkg::dbi_instr_t instr_i,
	input wire logic [15:0] pc_i,
	input wire logic [1:0] bank_i,
	input wire logic [7:0] acc_i,
	input wire logic [7:0] operand_i,
	input wire logic [7:0] psw_i,
	// results
	input wire logic [7:0] rd_addr_o,
	input wire logic rd_from_latch_o,
	input wire logic busy_o,
	input wire logic accept_o,
	input wire logic done_o,
	input wire logic [15:0] pc_o,
	input wire logic branch_o,
	input wire dbi_pkg::dbi_wr_t wr_o,
	input wire logic [7:0] psw_o
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	wire logic [7:0] op = instr_i.opcode;
	wire logic djd = op == 8'hD5;
	wire logic inc_a = accept_o && (op == 8'h04 || op == 8'h05 || op[7:3] == 5'h01);
	wire logic dj_a = accept_o && (djd || op[7:3] == 5'h1B);
	wire logic [7:0] rel = djd ? instr_i.byte2 : instr_i.byte1;
	wire logic [15:0] dj_nxt = pc_i + (djd ? 16'h3 : 16'h2);
	wire logic [15:0] dj_tgt = dj_nxt + {{8{rel[7]}}, rel};
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	sequence s_dj_done;
		!done_o && busy_o ##1 done_o && wr_o.we && !busy_o;
	endsequence
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	chk_inc_one_cycle: assert property (inc_a |=> done_o && wr_o.we)
		else $error("increment not done after one cycle");
	chk_dj_two_cycles: assert property (dj_a |=> s_dj_done)
		else $error("decrement branch not done after two cycles");
	chk_acc_inc: assert property (accept_o && op == 8'h04 |=>
		wr_o.to_acc && wr_o.data == $past(acc_i) + 8'h01)
		else $error("accumulator increment wrong");
	chk_inc_data_pc: assert property (inc_a && op != 8'h04 |=>
		wr_o.data == $past(operand_i) + 8'h01
		&& pc_o == $past(pc_i) + ($past(op) == 8'h05 ? 16'h2 : 16'h1))
		else $error("increment data or pc wrong");
	chk_wreg_addr: assert property (accept_o && (op[7:3] == 5'h01 || op[7:3] == 5'h1B) |->
		rd_addr_o == {3'h0, bank_i, op[2:0]})
		else $error("register operand address wrong");
	chk_latch_src: assert property (accept_o && (op == 8'h05 || djd) |->
		rd_from_latch_o == instr_i.byte1[7])
		else $error("latch source select wrong");
	chk_wr_target: assert property (accept_o && (op == 8'h05 || djd) |=>
		wr_o.addr == $past(instr_i.byte1) && wr_o.to_port_latch == $past(instr_i.byte1[7]))
		else $error("direct write target wrong");
	chk_flags_kept: assert property (accept_o |=> psw_o == $past(psw_i))
		else $error("status flags altered");
	chk_dj_target: assert property (dj_a |=> ##1
		wr_o.data == $past(operand_i, 2) - 8'h01
		&& branch_o == ($past(operand_i, 2) != 8'h01)
		&& pc_o == (($past(operand_i, 2) != 8'h01) ? $past(dj_tgt, 2) : $past(dj_nxt, 2)))
		else $error("decrement branch result or target wrong");
endmodule : dbi_exec_monitor

bind dbi_exec dbi_exec_monitor mon_u (.clk_i(clk_i), .nrst_i(nrst_i), .instr_i(instr_i),
	.pc_i(pc_i), .bank_i(bank_i), .acc_i(acc_i), .operand_i(operand_i), .psw_i(psw_i),
	.rd_addr_o(rd_addr_o), .rd_from_latch_o(rd_from_latch_o), .busy_o(busy_o),
	.accept_o(accept_o), .done_o(done_o), .pc_o(pc_o), .branch_o(branch_o), .wr_o(wr_o),
	.psw_o(psw_o));

// ---- tb/dbi_exec_tb_top.sv ----
/*
 * Self-checking bench for dbi_exec: increments, decrement branches, refusals.
 * Assumes the bench stands in for the core and drives every input.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module dbi_exec_tb_top;
	logic clk_i = 0, nrst_i = 0, start_i = 0;
	dbi_pkg::dbi_instr_t instr_i = '0;
	logic [15:0] pc_i = '0;
	logic [1:0] bank_i = '0;
	logic [7:0] acc_i = '0, operand_i = '0, psw_i = '0, rd_addr_o;
	logic rd_from_latch_o, busy_o, accept_o, done_o, branch_o;
	logic [15:0] pc_o;
	dbi_pkg::dbi_wr_t wr_o;
	logic [7:0] psw_o;
	int failures = 0, checks_done = 0;
	dbi_exec dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .start_i(start_i), .instr_i(instr_i),
		.pc_i(pc_i), .bank_i(bank_i), .acc_i(acc_i), .operand_i(operand_i), .psw_i(psw_i),
		.rd_addr_o(rd_addr_o), .rd_from_latch_o(rd_from_latch_o), .busy_o(busy_o),
		.accept_o(accept_o), .done_o(done_o), .pc_o(pc_o), .branch_o(branch_o),
		.wr_o(wr_o), .psw_o(psw_o));
	initial forever #10 clk_i = ~clk_i;
	// ----------------------------------------
	// shared issue and wait
	// ----------------------------------------
	task automatic run(input logic [7:0] op, b1, b2, opd, input logic [15:0] pc, input int cyc);
		int n;
		@(negedge clk_i);
		start_i = 1;
		instr_i = {op, b1, b2};
		pc_i = pc;
		operand_i = opd;
		psw_i = 8'hC5 ^ op;
		#1 `CHK("accept", 1'b1, accept_o)
		@(negedge clk_i);
		start_i = 0;
		n = 1;
		while (done_o !== 1'b1 && n < 5) begin
			@(negedge clk_i);
			n++;
		end
		`CHK("cycles", cyc, n)
		`CHK("psw", 8'hC5 ^ op, psw_o)
	endtask : run
	task automatic t_inc;
		for (int i = 0; i < 8; i++) begin
			bank_i = 2'(i);
			run(8'h08 | 8'(i), 8'h0, 8'h0, 8'h7E, 16'h0100, 1);
			`CHK("wr_addr", {3'h0, 2'(i), 3'(i)}, wr_o.addr)
			`CHK("wr_data", 8'h7F, wr_o.data)
			`CHK("pc", 16'h0101, pc_o)
			`CHK("rd_addr", {3'h0, 2'(i), 3'(i)}, rd_addr_o)
		end
		acc_i = 8'hFF;
		run(8'h04, 8'h0, 8'h0, 8'h11, 16'h0200, 1);
		`CHK("acc", {2'b11, 8'h00}, {wr_o.we, wr_o.to_acc, wr_o.data})
		run(8'h05, 8'h90, 8'h0, 8'hFF, 16'h0300, 1);
		`CHK("port", {1'b1, 8'h90, 8'h00}, {wr_o.to_port_latch, wr_o.addr, wr_o.data})
		`CHK("latch", 1'b1, rd_from_latch_o)
		`CHK("pc", 16'h0302, pc_o)
		run(8'h05, 8'h30, 8'h0, 8'h40, 16'h0300, 1);
		`CHK("ram", {1'b0, 8'h41}, {wr_o.to_port_latch, wr_o.data})
		$display("test inc done");
	endtask : t_inc
	task automatic t_dbnz;
		bank_i = 2'h2;
		run(8'hDB, 8'hFE, 8'h0, 8'h01, 16'h1000, 2);
		`CHK("nb", {1'b0, 8'h00, 16'h1002}, {branch_o, wr_o.data, pc_o})
		run(8'hDB, 8'h80, 8'h0, 8'h00, 16'h1000, 2);
		`CHK("wrap", {1'b1, 8'hFF, 16'h0F82}, {branch_o, wr_o.data, pc_o})
		run(8'hD5, 8'h45, 8'h7F, 8'h05, 16'hFFF0, 2);
		`CHK("dir", {1'b1, 8'h45, 8'h04, 16'h0072}, {branch_o, wr_o.addr, wr_o.data, pc_o})
		run(8'hD5, 8'h90, 8'h10, 8'h01, 16'h2000, 2);
		`CHK("dir_nb", {2'b01, 8'h00, 16'h2003}, {branch_o, wr_o.to_port_latch, wr_o.data, pc_o})
		$display("test dbnz done");
	endtask : t_dbnz
	task automatic t_refuse;
		@(negedge clk_i);
		start_i = 1;
		instr_i = {8'h06, 16'h0};
		#1 `CHK("bad_op", 1'b0, accept_o)
		instr_i = {8'hD5, 16'h0};
		@(negedge clk_i);
		instr_i = {8'h04, 16'h0};
		#1 `CHK("busy", 2'b10, {busy_o, accept_o})
		start_i = 0;
		repeat (3) @(negedge clk_i);
		$display("test refuse done");
	endtask : t_refuse
	task automatic t_reset;
		@(negedge clk_i);
		start_i = 1;
		instr_i = {8'hD5, 8'h30, 8'h02};
		@(negedge clk_i);
		start_i = 0;
		nrst_i = 0;
		#1 `CHK("rst_out", 1'b0, |{busy_o, done_o, branch_o, pc_o, wr_o, psw_o})
		repeat (2) @(negedge clk_i);
		nrst_i = 1;
		run(8'h0F, 8'h0, 8'h0, 8'h00, 16'h0400, 1);
		`CHK("after_rst", {8'h01, 16'h0401}, {wr_o.data, pc_o})
		$display("test reset done");
	endtask : t_reset
	task report_and_stop;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (20) @(posedge clk_i);
		@(negedge clk_i) nrst_i = 1;
		t_inc();
		t_dbnz();
		t_refuse();
		t_reset();
		report_and_stop();
	end
	initial begin
		#(20 * 400);
		failures++;
		report_and_stop();
	end
endmodule : dbi_exec_tb_top
